//--- ccr_map.svh
// Register offsets, field positions, reset values and scaling constants of the calibration bank
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
// ==========================================================
// Register pointers
`define CCR_OFFSET_TRIM_BASE 8'h0D
`define CCR_OFFSET_TRIM_LAST 8'h10
`define CCR_GAIN_TRIM_BASE 8'h11
`define CCR_GAIN_TRIM_LAST 8'h14
`define CCR_MAKER_IDENTITY_ADDR 8'hFE
`define CCR_PART_IDENTITY_ADDR 8'hFF
// ==========================================================
// Field layout
`define CCR_OFFSET_INT_MSB 15
`define CCR_OFFSET_INT_LSB 11
`define CCR_OFFSET_FRAC_BITS 11
`define CCR_GAIN_INT_MSB 15
`define CCR_GAIN_INT_LSB 14
`define CCR_GAIN_FRAC_BITS 14
// ==========================================================
// Reset values
`define CCR_OFFSET_TRIM_RESET 16'h0000
`define CCR_GAIN_TRIM_RESET 16'h4000
// ==========================================================
// Result scaling: result LSB is 2^-19 pF
`define CCR_RESULT_FRAC_BITS 19
`define CCR_OFFSET_ALIGN 8
`define CCR_DAC_STEP_NUM 34'h19
`define CCR_DAC_STEP_SHIFT 16
`endif

//--- ccr_pkg.sv
// Types shared by the calibration register bank
`default_nettype none
package ccr_pkg;
  // ==========================================================
  // Raw measurement entering the correction path
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [4:0] coarse_offset_dac;
    logic signed [31:0] raw;
  } ccr_meas_type;
  // ==========================================================
  // Corrected measurement leaving the correction path
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic signed [31:0] result;
  } ccr_result_type;
  // ==========================================================
  // Two-wire serial slave states
  typedef enum logic [8:0] {
    CCR_IDLE = 9'h001,
    CCR_ADDR = 9'h002,
    CCR_ACK_ADDR = 9'h004,
    CCR_PTR = 9'h008,
    CCR_ACK_PTR = 9'h010,
    CCR_WR = 9'h020,
    CCR_ACK_WR = 9'h040,
    CCR_RD = 9'h080,
    CCR_RD_ACK = 9'h100
  } ccr_state_type;
endpackage
`default_nettype wire

//--- ccr_cal_regs.sv
// Calibration register bank with two-wire serial slave and per-channel correction path
// Function
// - Offset trim is signed Q5.11 picofarads, integer in bits 15:11.
// - Offset trim is added to each channel result, span about -16 to +16 pF.
// - Four offset trims at pointers 0x0D to 0x10, channel one lowest.
// - Gain trim is unsigned Q2.14, integer in bits 15:14.
// - Applied gain equals trim divided by two to the fourteenth.
// - Four gain trims at pointers 0x11 to 0x14, channel one lowest.
// - Read-only maker identity returned at pointer 0xFE.
// - Read-only part identity returned at pointer 0xFF.
// - Trim is fine correction, combined with coarse DAC up to about 100 pF.
// - Coarse DAC code times 3.125 pF is subtracted from the result.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_map.svh"

module ccr_cal_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h50,
  // Arbitrary identity values
  parameter logic [15:0] MAKER_IDENTITY = 16'hA5C3,
  parameter logic [15:0] PART_IDENTITY = 16'h0C71
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire ccr_pkg::ccr_meas_type MEAS,
  output ccr_pkg::ccr_result_type CORR
);
  // ==========================================================
  // Bus pin edge detection
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= SCL_IN;
      sda_prev <= SDA_IN;
    end
  end
  assign scl_rise = SCL_IN & ~scl_prev;
  assign scl_fall = ~SCL_IN & scl_prev;
  assign start_cond = SCL_IN & scl_prev & sda_prev & ~SDA_IN;
  assign stop_cond = SCL_IN & scl_prev & ~sda_prev & SDA_IN;
  // ==========================================================
  // Register storage
  logic [15:0] offset_trim [4];
  logic [15:0] gain_trim [4];
  logic [15:0] next_offset_trim [4];
  logic [15:0] next_gain_trim [4];
  logic [7:0] pointer;
  function automatic logic [15:0] read_word(input logic [7:0] ptr);
    logic [7:0] idx;
    idx = 8'h00;
    read_word = 16'h0000;
    if (ptr >= `CCR_OFFSET_TRIM_BASE && ptr <= `CCR_OFFSET_TRIM_LAST) begin
      idx = ptr - `CCR_OFFSET_TRIM_BASE;
      read_word = offset_trim[idx[1:0]];
    end else if (ptr >= `CCR_GAIN_TRIM_BASE && ptr <= `CCR_GAIN_TRIM_LAST) begin
      idx = ptr - `CCR_GAIN_TRIM_BASE;
      read_word = gain_trim[idx[1:0]];
    end else if (ptr == `CCR_MAKER_IDENTITY_ADDR) begin
      read_word = MAKER_IDENTITY;
    end else if (ptr == `CCR_PART_IDENTITY_ADDR) begin
      read_word = PART_IDENTITY;
    end
  endfunction
  // ==========================================================
  // Serial slave state
  ccr_pkg::ccr_state_type state;
  ccr_pkg::ccr_state_type next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] next_pointer;
  logic [7:0] wr_msb;
  logic [7:0] next_wr_msb;
  logic [15:0] tx_word;
  logic [15:0] next_tx_word;
  logic lsb_phase;
  logic next_lsb_phase;
  logic is_read;
  logic next_is_read;
  logic master_ack;
  logic next_master_ack;
  logic sda_low;
  logic next_sda_low;
  always_comb begin
    logic [7:0] idx;
    logic [15:0] wdata;
    logic [15:0] rword;
    idx = 8'h00;
    wdata = {wr_msb, shreg};
    rword = read_word(pointer);
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_pointer = pointer;
    next_wr_msb = wr_msb;
    next_tx_word = tx_word;
    next_lsb_phase = lsb_phase;
    next_is_read = is_read;
    next_master_ack = master_ack;
    next_sda_low = sda_low;
    next_offset_trim = offset_trim;
    next_gain_trim = gain_trim;
    if (stop_cond) begin
      next_state = ccr_pkg::CCR_IDLE;
      next_sda_low = 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the pointer for a following read
      next_state = ccr_pkg::CCR_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_low = 1'b0;
    end else begin
      unique case (state)
        ccr_pkg::CCR_IDLE: begin
          next_sda_low = 1'b0;
        end
        ccr_pkg::CCR_ADDR, ccr_pkg::CCR_PTR, ccr_pkg::CCR_WR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], SDA_IN};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            next_sda_low = 1'b1;
            if (state == ccr_pkg::CCR_ADDR) begin
              next_is_read = shreg[0];
              next_sda_low = (shreg[7:1] == SLAVE_ADDR);
              next_state = (shreg[7:1] == SLAVE_ADDR) ? ccr_pkg::CCR_ACK_ADDR : ccr_pkg::CCR_IDLE;
            end else if (state == ccr_pkg::CCR_PTR) begin
              next_pointer = shreg;
              next_lsb_phase = 1'b0;
              next_state = ccr_pkg::CCR_ACK_PTR;
            end else begin
              next_state = ccr_pkg::CCR_ACK_WR;
              if (!lsb_phase) begin
                next_wr_msb = shreg;
              end else if (pointer >= `CCR_OFFSET_TRIM_BASE &&
                           pointer <= `CCR_OFFSET_TRIM_LAST) begin
                idx = pointer - `CCR_OFFSET_TRIM_BASE;
                next_offset_trim[idx[1:0]] = wdata;
              end else if (pointer >= `CCR_GAIN_TRIM_BASE &&
                           pointer <= `CCR_GAIN_TRIM_LAST) begin
                idx = pointer - `CCR_GAIN_TRIM_BASE;
                next_gain_trim[idx[1:0]] = wdata;
              end
              // Identity pointers and unmapped pointers drop the word
              next_lsb_phase = ~lsb_phase;
            end
          end
        end
        ccr_pkg::CCR_ACK_ADDR: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (is_read) begin
              next_tx_word = rword;
              next_lsb_phase = 1'b0;
              next_sda_low = ~rword[15];
              next_state = ccr_pkg::CCR_RD;
            end else begin
              next_sda_low = 1'b0;
              next_state = ccr_pkg::CCR_PTR;
            end
          end
        end
        ccr_pkg::CCR_ACK_PTR, ccr_pkg::CCR_ACK_WR: begin
          if (scl_fall) begin
            next_sda_low = 1'b0;
            next_state = ccr_pkg::CCR_WR;
          end
        end
        ccr_pkg::CCR_RD: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_tx_word = {tx_word[14:0], 1'b0};
            if (bit_cnt == 4'h7) begin
              next_sda_low = 1'b0;
              next_state = ccr_pkg::CCR_RD_ACK;
            end else begin
              next_sda_low = ~tx_word[14];
            end
          end
        end
        ccr_pkg::CCR_RD_ACK: begin
          if (scl_rise) begin
            next_master_ack = ~SDA_IN;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (master_ack) begin
              // After the low byte the word is sent again from its high byte
              next_tx_word = lsb_phase ? rword : tx_word;
              next_lsb_phase = ~lsb_phase;
              next_sda_low = lsb_phase ? ~rword[15] : ~tx_word[15];
              next_state = ccr_pkg::CCR_RD;
            end else begin
              next_state = ccr_pkg::CCR_IDLE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= ccr_pkg::CCR_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      wr_msb <= 8'h00;
      tx_word <= 16'h0000;
      lsb_phase <= 1'b0;
      is_read <= 1'b0;
      master_ack <= 1'b0;
      sda_low <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        offset_trim[i] <= `CCR_OFFSET_TRIM_RESET;
        gain_trim[i] <= `CCR_GAIN_TRIM_RESET;
      end
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      pointer <= next_pointer;
      wr_msb <= next_wr_msb;
      tx_word <= next_tx_word;
      lsb_phase <= next_lsb_phase;
      is_read <= next_is_read;
      master_ack <= next_master_ack;
      sda_low <= next_sda_low;
      offset_trim <= next_offset_trim;
      gain_trim <= next_gain_trim;
    end
  end
  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low;
  // ==========================================================
  // Correction path, two stages
  logic s1_valid;
  logic [1:0] s1_channel;
  logic signed [33:0] s1_sum;
  logic [15:0] s1_gain;
  logic next_s1_valid;
  logic [1:0] next_s1_channel;
  logic signed [33:0] next_s1_sum;
  logic [15:0] next_s1_gain;
  ccr_pkg::ccr_result_type next_corr;
  always_comb begin
    logic [15:0] off;
    logic signed [33:0] dac_cap;
    logic signed [33:0] trim_cap;
    logic signed [50:0] prod;
    off = offset_trim[MEAS.channel];
    // Code times 25/8 pF, aligned to the result LSB
    dac_cap = ({29'h0, MEAS.coarse_offset_dac} * `CCR_DAC_STEP_NUM) << `CCR_DAC_STEP_SHIFT;
    // Sign-extended Q5.11 moved up to Q.19
    trim_cap = {{10{off[`CCR_OFFSET_INT_MSB]}}, off, 8'h00};
    // Unsigned Q2.14 gain: multiply then drop fourteen fraction bits
    prod = s1_sum * $signed({1'b0, s1_gain});
    next_s1_valid = MEAS.valid;
    next_s1_channel = MEAS.channel;
    // Coarse subtraction plus fine trim reaches about 100 pF
    next_s1_sum = {{2{MEAS.raw[31]}}, MEAS.raw} - dac_cap + trim_cap;
    next_s1_gain = gain_trim[MEAS.channel];
    next_corr.valid = s1_valid;
    next_corr.channel = s1_channel;
    // Upper bits are dropped; results beyond 32 bits wrap
    next_corr.result = prod[31 + `CCR_GAIN_FRAC_BITS:`CCR_GAIN_FRAC_BITS];
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s1_valid <= 1'b0;
      s1_channel <= 2'h0;
      s1_sum <= 34'h0;
      s1_gain <= 16'h0000;
      CORR <= '0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_channel <= next_s1_channel;
      s1_sum <= next_s1_sum;
      s1_gain <= next_s1_gain;
      CORR <= next_corr;
    end
  end
endmodule // ccr_cal_regs
`default_nettype wire

//--- ccr_cal_regs_properties.sv
// Port-level checker for the calibration register bank
`timescale 1ns/10ps
`default_nettype none
module ccr_cal_regs_properties (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire ccr_pkg::ccr_meas_type MEAS,
  input wire ccr_pkg::ccr_result_type CORR
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  // ==========================================================
  // Correction path
  sequence meas_taken;
    MEAS.valid;
  endsequence
  sequence corr_two_later;
    ##2 CORR.valid;
  endsequence
  chk_corr_latency: assert property (meas_taken |-> corr_two_later)
    else $error("corrected result not two cycles after measurement");
  chk_corr_cause: assert property (CORR.valid |-> $past(MEAS.valid, 2))
    else $error("corrected result without a measurement");
  chk_corr_channel: assert property (meas_taken |-> ##2 CORR.channel == $past(MEAS.channel, 2))
    else $error("corrected result carries the wrong channel");
  chk_corr_single: assert property (MEAS.valid ##1 !MEAS.valid |-> ##2 !CORR.valid)
    else $error("corrected result longer than one cycle");
  // ==========================================================
  // Serial data pin; open drain, so only the enable may move
  chk_sda_drain: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  chk_oe_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL_IN))
    else $error("data pin changed while clock high");
  chk_ack_holds: assert property ($rose(SDA_OE) |-> SDA_OE[*4])
    else $error("data pin pull too short");
  chk_ack_start_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
    else $error("data pin pull began in clock high");
endmodule // ccr_cal_regs_properties
bind ccr_cal_regs ccr_cal_regs_properties i_props (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MEAS(MEAS), .CORR(CORR));
`default_nettype wire

//--- ccr_host_model.sv
// Two-wire host model issuing word writes and reads
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // ==========================================================
  // Bit timing: five clocks a phase, data moves two clocks after each falling clock edge
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(2);
  endtask
  // Start is edge_pair(1,0), stop is edge_pair(0,1)
  task automatic edge_pair(input logic first, input logic second);
    scl <= 1'b0;
    tick(2);
    sda_drv <= first;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_drv <= second;
    tick(3);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask
  // ==========================================================
  // Word transfers, high byte first
  task automatic write_word(input logic [6:0] addr, input logic [7:0] ptr, input logic [15:0] d,
                            output logic [3:0] acks);
    logic [7:0] rx;
    edge_pair(1'b1, 1'b0);
    xfer({addr, 1'b0}, 1'b1, rx, acks[3]);
    xfer(ptr, 1'b1, rx, acks[2]);
    xfer(d[15:8], 1'b1, rx, acks[1]);
    xfer(d[7:0], 1'b1, rx, acks[0]);
    edge_pair(1'b0, 1'b1);
  endtask
  task automatic read_word(input logic [6:0] addr, input logic [7:0] ptr, output logic [15:0] d,
                           output logic [2:0] acks);
    logic [7:0] rx;
    edge_pair(1'b1, 1'b0);
    xfer({addr, 1'b0}, 1'b1, rx, acks[2]);
    xfer(ptr, 1'b1, rx, acks[1]);
    edge_pair(1'b1, 1'b0);
    xfer({addr, 1'b1}, 1'b1, rx, acks[0]);
    xfer(8'hFF, 1'b0, d[15:8], rx[0]);
    xfer(8'hFF, 1'b1, d[7:0], rx[0]);
    edge_pair(1'b0, 1'b1);
  endtask
endmodule // ccr_host_model
`default_nettype wire

//--- tb_ccr_cal_regs.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/10ps
`default_nettype none
`include "ccr_map.svh"
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_ccr_cal_regs;
  localparam logic [6:0] DEV = 7'h50;
  // Arbitrary identity values
  localparam logic [15:0] MAKER_ID = 16'h3C96;
  localparam logic [15:0] PART_ID = 16'h7E21;
  logic sys_clk;
  logic reset;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  wire logic sda;
  ccr_pkg::ccr_meas_type meas;
  ccr_pkg::ccr_result_type corr;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] rdata;
  logic [2:0] racks;
  logic [3:0] wacks;
  logic [15:0] off [4] = '{16'hF800, 16'h7FFF, 16'h8000, 16'h0800};
  logic [15:0] gain [4] = '{16'h8000, 16'hFFFF, 16'h2000, 16'h0000};
  logic [4:0] code [4] = '{5'h00, 5'h1F, 5'h10, 5'h01};
  // Pull-up: a line released by both parties reads high
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  ccr_cal_regs #(.SLAVE_ADDR(DEV), .MAKER_IDENTITY(MAKER_ID), .PART_IDENTITY(PART_ID)) i_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .MEAS(meas), .CORR(corr));
  ccr_host_model i_host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // Access and measurement tasks
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    i_host.write_word(DEV, ptr, d, wacks);
    `CHECK("write acks", 4'h0, wacks)
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    i_host.read_word(DEV, ptr, rdata, racks);
    `CHECK("read acks", 3'h0, racks)
    `CHECK("read data", exp, rdata)
  endtask
  task automatic measure(input logic [1:0] ch, input logic [4:0] dac, input logic [31:0] raw,
                         input logic [15:0] o, input logic [15:0] g);
    longint s;
    // One coarse step of 3.125 pF is 1638400 result units
    s = longint'($signed(raw)) - longint'(dac) * 1638400 + (longint'($signed(o)) <<< 8);
    @(posedge sys_clk);
    meas <= '{valid: 1'b1, channel: ch, coarse_offset_dac: dac, raw: raw};
    @(posedge sys_clk);
    meas.valid <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHECK("corr valid", 1'b1, corr.valid)
    `CHECK("corr channel", ch, corr.channel)
    `CHECK("corr result", 32'((s * longint'(g)) >>> 14), corr.result)
    // Return on a clock edge so the next bus access starts there
    @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    meas = '0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(`CCR_OFFSET_TRIM_BASE + i), `CCR_OFFSET_TRIM_RESET);
      rd(8'(`CCR_GAIN_TRIM_BASE + i), `CCR_GAIN_TRIM_RESET);
    end
    measure(2'h3, 5'h1F, 32'h0300_0000, `CCR_OFFSET_TRIM_RESET, `CCR_GAIN_TRIM_RESET);
    for (int i = 0; i < 4; i++) begin
      wr(8'(`CCR_OFFSET_TRIM_BASE + i), off[i]);
      wr(8'(`CCR_GAIN_TRIM_BASE + i), gain[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'(`CCR_OFFSET_TRIM_BASE + i), off[i]);
      rd(8'(`CCR_GAIN_TRIM_BASE + i), gain[i]);
      measure(2'(i), code[i], 32'h0040_0000 - 32'(i) * 32'h0030_0000, off[i], gain[i]);
    end
    wr(`CCR_MAKER_IDENTITY_ADDR, 16'h0000);
    wr(`CCR_PART_IDENTITY_ADDR, 16'hFFFF);
    rd(`CCR_MAKER_IDENTITY_ADDR, MAKER_ID);
    rd(`CCR_PART_IDENTITY_ADDR, PART_ID);
    wr(8'h15, 16'hBEEF);
    rd(8'h15, 16'h0000);
    rd(8'h0C, 16'h0000);
    // A foreign address must leave the bank untouched
    i_host.write_word(7'h51, `CCR_OFFSET_TRIM_BASE, 16'h1111, wacks);
    `CHECK("foreign acks", 4'hF, wacks)
    rd(`CCR_OFFSET_TRIM_BASE, off[0]);
    stop_test();
  end
endmodule // tb_ccr_cal_regs
`default_nettype wire
